// file: hw/flash_ctrl_defs.svh
// constants for the flash erase, poll and identification host controller
`ifndef FLASH_CTRL_DEFS_SVH
`define FLASH_CTRL_DEFS_SVH
`define CLK_PERIOD_NS     100
`define STROBE_NS         100
`define STROBE_CYC        ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIN_HIGH_NS       50
`define MIN_HIGH_CYC      (((`MIN_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 1)
`define CHIP_ERASE_MAX_S  26
`define SECT_ERASE_MAX_S  5
`define CYC_PER_S         10000000
`define ADDR_UNLOCK1      12'h555
`define ADDR_UNLOCK2      12'hAAA
`define DATA_UNLOCK1      8'hAA
`define DATA_UNLOCK2      8'h55
`define DATA_ERASE_SETUP  8'h80
`define DATA_CHIP_ERASE   8'h10
`define DATA_SECT_ERASE   8'h30
`define DATA_ID_ENTRY     8'h90
`define DATA_ID_EXIT      8'hF0
`define TOGGLE_BIT        6
`define CMD_ADDR_W        12
`endif

// file: hw/flash_ctrl_pkg.sv
// types for the flash erase, poll and identification host controller
package flash_ctrl_pkg;
  typedef enum logic [2:0] {
    OP_CHIP_ERASE,
    OP_SECT_ERASE,
    OP_ID_ENTRY,
    OP_ID_EXIT_SHORT,
    OP_ID_EXIT_LONG,
    OP_READ
  } op_t;
endpackage

// file: hw/bus_cycle_if.sv
// one bus cycle request between the sequencer and the pin driver
`timescale 1ns/1ns
interface bus_cycle_if;
  logic        req;
  logic        wr;
  logic        done;
  logic [18:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport drv (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// file: hw/flash_pin_driver.sv
// drives one read or write strobe on the flash pins
`timescale 1ns/1ns
`include "flash_ctrl_defs.svh"
module flash_pin_driver
  import flash_ctrl_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rst_b,
  input  wire logic   ce,
  bus_cycle_if.drv    cyc,
  input  wire logic [15:0] dq_in,
  output logic        ce_b,
  output logic        oe_b,
  output logic        we_b,
  output logic [18:0] addr,
  output logic [15:0] dq_out,
  output logic        dq_oe
);
  typedef enum logic [1:0] {D_IDLE, D_STROBE, D_HIGH} drv_state_t;
  drv_state_t  state_r;
  logic [3:0]  cnt_r;
  logic [15:0] dq_s1_r, dq_s2_r;

  wire strobe_end = (state_r == D_STROBE) && (cnt_r == 4'(`STROBE_CYC - 1));
  wire high_end   = (state_r == D_HIGH) && (cnt_r == 4'(`MIN_HIGH_CYC - 1));

  assign cyc.done  = high_end;
  // the second synchroniser stage holds the strobed data on the very edge that done is high
  assign cyc.rdata = dq_s2_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dq_s1_r <= 16'h0000;
      dq_s2_r <= 16'h0000;
    end else if (ce) begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= D_IDLE;
      cnt_r   <= 4'h0;
      ce_b    <= 1'b1;
      oe_b    <= 1'b1;
      we_b    <= 1'b1;
      addr    <= 19'h00000;
      dq_out  <= 16'h0000;
      dq_oe   <= 1'b0;
    end else if (ce) begin
      case (state_r)
        D_IDLE: begin
          cnt_r <= 4'h0;
          if (cyc.req) begin
            state_r <= D_STROBE;
            addr    <= cyc.addr;
            dq_out  <= cyc.wdata;
            dq_oe   <= cyc.wr;
            ce_b    <= 1'b0;
            we_b    <= !cyc.wr;
            oe_b    <= cyc.wr;
          end
        end
        D_STROBE: begin
          cnt_r <= cnt_r + 4'h1;
          if (strobe_end) begin
            state_r <= D_HIGH;
            cnt_r   <= 4'h0;
            ce_b    <= 1'b1;
            we_b    <= 1'b1;
            oe_b    <= 1'b1;
          end
        end
        default: begin
          cnt_r <= cnt_r + 4'h1;
          dq_oe <= 1'b0;
          if (high_end) state_r <= D_IDLE;
        end
      endcase
    end
  end

  property p_oe_high_on_write;
    @(posedge clk) disable iff (!rst_b) (!we_b && !ce_b) |-> oe_b;
  endproperty
  a_oe_high_on_write: assert property (p_oe_high_on_write) else $error("oe low during write");
  property p_high_gap;
    @(posedge clk) disable iff (!rst_b) $rose(oe_b) |=> oe_b;
  endproperty
  a_high_gap: assert property (p_high_gap) else $error("strobe high gap too short");
  property p_no_drive_on_read;
    @(posedge clk) disable iff (!rst_b) !oe_b |-> !dq_oe;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("data driven during read");
endmodule // flash_pin_driver

// file: hw/flash_erase_poll_id_ctrl.sv
// host sequencer for flash erase, toggle polling and identification
`timescale 1ns/1ns
`include "flash_ctrl_defs.svh"
module flash_erase_poll_id_ctrl
  import flash_ctrl_pkg::*;
#(
  parameter int unsigned CHIP_TIMEOUT_CYC = `CHIP_ERASE_MAX_S * `CYC_PER_S,
  parameter int unsigned SECT_TIMEOUT_CYC = `SECT_ERASE_MAX_S * `CYC_PER_S
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        cmd_valid,
  input  wire logic [2:0]  cmd_op,
  input  wire logic [18:0] cmd_addr,
  output logic             cmd_ready,
  output logic             resp_valid,
  output logic             resp_timeout,
  output logic [15:0]      resp_data,
  output logic             busy,
  output logic             flash_ce_b,
  output logic             flash_oe_b,
  output logic             flash_we_b,
  output logic [18:0]      flash_addr,
  input  wire logic [15:0] flash_dq_in,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe
);
  typedef enum logic [2:0] {S_IDLE, S_WRITE, S_POLL_A, S_POLL_B, S_READ, S_DONE} seq_state_t;
  seq_state_t  state_r;
  op_t         op_r;
  logic [18:0] addr_r;
  logic [2:0]  step_r;
  logic [15:0] prev_r;
  logic [31:0] wait_r;
  logic        tmo_r;
  logic [15:0] data_r;
  logic        resp_r;

  bus_cycle_if cyc ();

  flash_pin_driver u_drv (
    .clk    (clk),
    .rst_b  (rst_b),
    .ce     (clk_en),
    .cyc    (cyc),
    .dq_in  (flash_dq_in),
    .ce_b   (flash_ce_b),
    .oe_b   (flash_oe_b),
    .we_b   (flash_we_b),
    .addr   (flash_addr),
    .dq_out (flash_dq_out),
    .dq_oe  (flash_dq_oe)
  );

  // number of write cycles per op
  function automatic logic [2:0] op_len(input op_t op);
    case (op)
      OP_CHIP_ERASE, OP_SECT_ERASE: op_len = 3'd6;
      OP_ID_ENTRY, OP_ID_EXIT_LONG: op_len = 3'd3;
      OP_ID_EXIT_SHORT:             op_len = 3'd1;
      default:                      op_len = 3'd0;
    endcase
  endfunction

  // write address and data for step s; only A11-A0 and the low byte matter, except the full sector address on the last sector erase write
  function automatic logic [27:0] op_word(input op_t op, input logic [2:0] s, input logic [18:0] a);
    logic [11:0] ca;
    logic [7:0]  cd;
    ca = `ADDR_UNLOCK1;
    cd = `DATA_UNLOCK1;
    if (op == OP_ID_EXIT_SHORT) begin
      cd = `DATA_ID_EXIT;
    end else if (s == 3'd1 || s == 3'd4) begin
      ca = `ADDR_UNLOCK2;
      cd = `DATA_UNLOCK2;
    end else if (s == 3'd2) begin
      cd = (op == OP_ID_ENTRY) ? `DATA_ID_ENTRY :
           (op == OP_ID_EXIT_LONG) ? `DATA_ID_EXIT : `DATA_ERASE_SETUP;
    end else if (s == 3'd5) begin
      cd = (op == OP_CHIP_ERASE) ? `DATA_CHIP_ERASE : `DATA_SECT_ERASE;
      if (op == OP_SECT_ERASE) begin
        // the sector address goes out whole, the only write that keeps upper address bits
        return {1'b0, a, cd};
      end
    end
    op_word = {8'h00, ca, cd};
  endfunction

  wire [27:0] word      = op_word(op_r, step_r, addr_r);
  wire        is_erase  = (op_r == OP_CHIP_ERASE) || (op_r == OP_SECT_ERASE);
  wire [31:0] limit     = (op_r == OP_CHIP_ERASE) ? CHIP_TIMEOUT_CYC : SECT_TIMEOUT_CYC;
  wire        toggled   = cyc.rdata[`TOGGLE_BIT] != prev_r[`TOGGLE_BIT];
  // timeout judged only after a toggled pair, so a finished erase is never reported as late
  wire        expired   = wait_r >= limit;

  assign cyc.req   = (state_r == S_WRITE) || (state_r == S_POLL_A) || (state_r == S_POLL_B) || (state_r == S_READ);
  assign cyc.wr    = (state_r == S_WRITE);
  assign cyc.addr  = (state_r == S_WRITE) ? word[26:8] : addr_r;
  assign cyc.wdata = {8'h00, word[7:0]};
  assign cmd_ready = (state_r == S_IDLE);
  assign busy      = (state_r != S_IDLE);
  assign resp_valid   = resp_r;
  assign resp_timeout = tmo_r;
  assign resp_data    = data_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      op_r    <= OP_READ;
      addr_r  <= 19'h00000;
      step_r  <= 3'h0;
      prev_r  <= 16'h0000;
      wait_r  <= 32'h0;
      tmo_r   <= 1'b0;
      data_r  <= 16'h0000;
      resp_r  <= 1'b0;
    end else if (clk_en) begin
      resp_r <= 1'b0;
      if (state_r != S_IDLE) wait_r <= wait_r + 32'h1;
      case (state_r)
        S_IDLE: begin
          wait_r <= 32'h0;
          if (cmd_valid) begin
            op_r    <= op_t'(cmd_op);
            addr_r  <= cmd_addr;
            step_r  <= 3'h0;
            tmo_r   <= 1'b0;
            state_r <= (op_t'(cmd_op) == OP_READ) ? S_READ : S_WRITE;
          end
        end
        S_WRITE: if (cyc.done) begin
          step_r <= step_r + 3'h1;
          if (step_r == op_len(op_r) - 3'h1) begin
            state_r <= is_erase ? S_POLL_A : S_DONE;
            wait_r  <= 32'h0;
          end
        end
        S_POLL_A: if (cyc.done) begin
          prev_r  <= cyc.rdata;
          state_r <= S_POLL_B;
        end
        S_POLL_B: if (cyc.done) begin
          prev_r <= cyc.rdata;
          // start level ignored; only a flip between reads means busy
          if (!toggled) begin
            data_r  <= cyc.rdata;
            state_r <= S_DONE;
          end else if (expired) begin
            tmo_r   <= 1'b1;
            data_r  <= cyc.rdata;
            state_r <= S_DONE;
          end
        end
        S_READ: if (cyc.done) begin
          data_r  <= cyc.rdata;
          state_r <= S_DONE;
        end
        default: begin
          resp_r  <= 1'b1;
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  sequence s_last_erase_write;
    (state_r == S_WRITE) && is_erase && (step_r == 3'd5) && cyc.done;
  endsequence
  property p_erase_then_poll;
    @(posedge clk) disable iff (!rst_b) clk_en throughout (s_last_erase_write ##1 1) |-> state_r == S_POLL_A;
  endproperty
  a_erase_then_poll: assert property (p_erase_then_poll) else $error("no poll after erase");
  property p_chip_code;
    @(posedge clk) disable iff (!rst_b)
      (state_r == S_WRITE && op_r == OP_CHIP_ERASE && step_r == 3'd5) |-> (word[7:0] == `DATA_CHIP_ERASE && word[26:8] == 19'(`ADDR_UNLOCK1));
  endproperty
  a_chip_code: assert property (p_chip_code) else $error("bad chip erase word");
  property p_sect_code;
    @(posedge clk) disable iff (!rst_b)
      (state_r == S_WRITE && op_r == OP_SECT_ERASE && step_r == 3'd5) |-> (word[7:0] == `DATA_SECT_ERASE && word[26:8] == addr_r);
  endproperty
  a_sect_code: assert property (p_sect_code) else $error("bad sector erase word");
  property p_poll_addr_stable;
    @(posedge clk) disable iff (!rst_b) (!flash_ce_b && !flash_oe_b) |-> flash_addr == addr_r && flash_we_b;
  endproperty
  a_poll_addr_stable: assert property (p_poll_addr_stable) else $error("poll address moved");
  property p_stop_when_stable;
    @(posedge clk) disable iff (!rst_b)
      (clk_en && state_r == S_POLL_B && cyc.done && !toggled) |=> state_r == S_DONE && !tmo_r;
  endproperty
  a_stop_when_stable: assert property (p_stop_when_stable) else $error("missed erase end");
  property p_high_byte_zero;
    @(posedge clk) disable iff (!rst_b) (!flash_we_b && !flash_ce_b) |-> flash_dq_out[15:8] == 8'h00 && flash_dq_oe;
  endproperty
  a_high_byte_zero: assert property (p_high_byte_zero) else $error("upper data byte driven");
  property p_cmd_addr_low;
    @(posedge clk) disable iff (!rst_b)
      (!flash_we_b && !flash_ce_b && !(op_r == OP_SECT_ERASE && step_r == 3'd5)) |-> flash_addr[18:12] == 7'h00;
  endproperty
  a_cmd_addr_low: assert property (p_cmd_addr_low) else $error("upper address bits set on command write");
  property p_erase_data;
    @(posedge clk) disable iff (!rst_b) (!flash_we_b && !flash_ce_b && is_erase && step_r == 3'd5) |->
      flash_dq_out[7:0] == ((op_r == OP_CHIP_ERASE) ? `DATA_CHIP_ERASE : `DATA_SECT_ERASE);
  endproperty
  a_erase_data: assert property (p_erase_data) else $error("wrong erase data byte");
  sequence s_busy_pair;
    clk_en && state_r == S_POLL_B && cyc.done && toggled && !expired;
  endsequence
  property p_keep_polling;
    @(posedge clk) disable iff (!rst_b) s_busy_pair |=> state_r == S_POLL_B && !resp_valid;
  endproperty
  a_keep_polling: assert property (p_keep_polling) else $error("polling stopped while toggling");
  property p_resp_pulse;
    @(posedge clk) disable iff (!rst_b) resp_valid |=> !resp_valid || !clk_en;
  endproperty
  a_resp_pulse: assert property (p_resp_pulse) else $error("response held");
  property p_exit_short;
    @(posedge clk) disable iff (!rst_b) (state_r == S_WRITE && op_r == OP_ID_EXIT_SHORT) |-> word[7:0] == `DATA_ID_EXIT;
  endproperty
  a_exit_short: assert property (p_exit_short) else $error("bad id exit");
endmodule // flash_erase_poll_id_ctrl

// file: testbench/flash_model.sv
// behavioural parallel flash device for the erase, poll and id host controller
`timescale 1ns/1ns
module flash_model #(
  parameter int          BUSY_READS = 8,
  parameter logic [15:0] MAKER_CODE = 16'h0A5A, // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h0B6B  // arbitrary value
) (
  input  wire logic        ce_b,
  input  wire logic        oe_b,
  input  wire logic        we_b,
  input  wire logic [18:0] addr,
  input  wire logic [15:0] dq_in,
  input  wire logic        hang,
  output logic [15:0]      dq_out
);
  logic [2:0]  step_r = 3'h0;
  logic        id_r   = 1'b0;
  logic        ers_r  = 1'b0;
  logic        tog_r  = 1'b0;
  int          left_r = 0;
  logic [15:0] last_r = 16'h0000;
  logic [11:0] wa;
  logic [7:0]  wd;
  wire         rd_on = !ce_b && !oe_b && we_b;
  wire         wr_on = !ce_b && !we_b;
  wire [15:0]  rd_val = (left_r > 0) ? {9'h000, tog_r, 6'h00} :
                        id_r ? (addr[0] ? PART_CODE : MAKER_CODE) :
                        ers_r ? 16'hFFFF : addr[15:0];
  // a released bus shows the inverse of the last value, never a held copy
  assign dq_out = rd_on ? rd_val : ~last_r;
  always @* if (rd_on) last_r = rd_val;
  always @* if (wr_on) begin
    wa = addr[11:0];
    wd = dq_in[7:0];
  end
  // busy ends after a bounded number of reads; hang models a stuck erase
  always @(negedge rd_on) if (left_r > 0) begin
    tog_r = ~tog_r;
    if (!hang) left_r = left_r - 1;
  end
  always @(negedge wr_on) begin
    if (wd == 8'hF0) begin
      id_r = 1'b0;
      step_r = 3'h0;
    end else begin
      case (step_r)
        3'h0, 3'h3: step_r = (wa == 12'h555 && wd == 8'hAA) ? step_r + 3'h1 : 3'h0;
        3'h1, 3'h4: step_r = (wa == 12'hAAA && wd == 8'h55) ? step_r + 3'h1 : 3'h0;
        3'h2: begin
          step_r = (wa == 12'h555 && wd == 8'h80) ? 3'h3 : 3'h0;
          if (wa == 12'h555 && wd == 8'h90) id_r = 1'b1;
        end
        3'h5: begin
          if (wd == 8'h10 && wa == 12'h555) left_r = 2 * BUSY_READS;
          if (wd == 8'h30) left_r = BUSY_READS;
          ers_r = ers_r | wd == 8'h10 | wd == 8'h30;
          step_r = 3'h0;
        end
        default: step_r = 3'h0;
      endcase
    end
  end
endmodule // flash_model

// file: testbench/flash_erase_poll_id_ctrl_tb.sv
// testbench for the flash erase, poll and identification host controller
`timescale 1ns/1ns
module flash_erase_poll_id_ctrl_tb;
  logic clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, hang = 1'b0;
  logic [2:0]  cmd_op = 3'h0;
  logic [18:0] cmd_addr = 19'h00000, poll_a = 19'h00000;
  logic cmd_ready, resp_valid, resp_timeout, busy, ce_b, oe_b, we_b, dq_oe;
  logic [18:0] f_addr;
  logic [15:0] resp_data, dq_in, dq_out;
  logic [34:0] wq[$];
  int errors = 0, comparisons = 0, hi_cnt = 0;
  always #50 clk = ~clk;
  flash_erase_poll_id_ctrl #(.CHIP_TIMEOUT_CYC(2000), .SECT_TIMEOUT_CYC(2000)) uut (
    .clk(clk), .rst_b(rst_b), .clk_en(1'b1), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_timeout(resp_timeout),
    .resp_data(resp_data), .busy(busy), .flash_ce_b(ce_b), .flash_oe_b(oe_b), .flash_we_b(we_b),
    .flash_addr(f_addr), .flash_dq_in(dq_in), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe));
  flash_model fm (.ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .addr(f_addr), .dq_in(dq_out),
    .hang(hang), .dq_out(dq_in));
  task automatic check(input logic [34:0] seen, input logic [34:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // pin monitor: strobes last one cycle, so the falling edge sees them settled
  always @(negedge clk) if (rst_b) begin
    if (!ce_b && !we_b) begin
      wq.push_back({f_addr, dq_out});
      check(oe_b, 1'b1);
      check(dq_oe, 1'b1);
    end
    if (!ce_b && !oe_b) begin
      check(f_addr, poll_a);
      check(dq_oe, 1'b0);
      check(hi_cnt >= 1, 1'b1);
      hi_cnt = 0;
    end else hi_cnt++;
  end
  task automatic do_op(input logic [2:0] op, input logic [18:0] a);
    int n;
    wq.delete();
    poll_a = a;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (resp_valid !== 1'b1 && n < 5000);
    check(resp_valid, 1'b1);
  endtask
  task automatic t_reset();
    check({cmd_ready, ce_b, oe_b, we_b, dq_oe, resp_valid}, 6'b111100);
  endtask
  task automatic t_read(input logic [18:0] a, input logic [15:0] exp);
    do_op(3'h5, a);
    check(resp_data, exp);
  endtask
  task automatic t_id();
    t_read(19'h00003, 16'h0003);
    do_op(3'h2, 19'h00000);
    check(wq[2], {19'h00555, 16'h0090});
    t_read(19'h00000, 16'h0A5A);
    t_read(19'h00001, 16'h0B6B);
    do_op(3'h3, 19'h00000);
    t_read(19'h00005, 16'h0005);
    do_op(3'h2, 19'h00000);
    do_op(3'h4, 19'h00000);
    check(wq.size(), 3);
    t_read(19'h00001, 16'h0001);
  endtask
  task automatic t_erase(input logic [2:0] op, input logic [18:0] a, input logic [34:0] last);
    do_op(op, a);
    check(wq.size(), 6);
    check(wq[0], {19'h00555, 16'h00AA});
    check(wq[2], {19'h00555, 16'h0080});
    check(wq[5], last);
    check(resp_timeout, 1'b0);
    check(resp_data, 16'hFFFF);
    check(busy, 1'b0);
  endtask
  task automatic t_stuck();
    hang = 1'b1;
    do_op(3'h0, 19'h00040);
    check(resp_timeout, 1'b1);
    hang = 1'b0;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_id();
    t_erase(3'h1, 19'h7A123, {19'h7A123, 16'h0030});
    t_erase(3'h1, 19'h08000, {19'h08000, 16'h0030});
    t_erase(3'h0, 19'h00100, {19'h00555, 16'h0010});
    t_stuck();
    finish_test();
  end
  initial begin
    #(40000 * 100);
    errors++;
    finish_test();
  end
endmodule // flash_erase_poll_id_ctrl_tb
